/* File: src/spsf_pkg.sv */
// Purpose: Shared constants and types for the serial port status flags.
// Assumes: Byte wide control register, small word addressed register port.
// Notes:   Offsets of the register port are fixed here and nowhere else.

package spsf_pkg;

  // ****************************************************************
  // Register port geometry
  // ****************************************************************
  localparam int unsigned SPSF_AW = 4;
  localparam int unsigned SPSF_DW = 8;
  localparam int unsigned SPSF_IW = 2;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [SPSF_AW-1:0] SPSF_OFF_CTRL = 4'h0;
  localparam logic [SPSF_AW-1:0] SPSF_OFF_CTRL_SET = 4'h1;
  localparam logic [SPSF_AW-1:0] SPSF_OFF_CTRL_CLR = 4'h2;
  localparam logic [SPSF_AW-1:0] SPSF_OFF_IRQ_STAT = 4'h3;
  localparam logic [SPSF_AW-1:0] SPSF_OFF_IRQ_MASK = 4'h4;

  // ****************************************************************
  // Reset values, plus the all-ones interrupt clear mask
  // ****************************************************************
  localparam logic [SPSF_DW-1:0] SPSF_CTRL_RST = 8'h00;
  localparam logic [SPSF_DW-1:0] SPSF_RDATA_RST = 8'h00;
  localparam logic [SPSF_IW-1:0] SPSF_IRQ_RST = 2'h0;
  localparam logic [SPSF_IW-1:0] SPSF_IRQ_ALL = 2'h3;

  // ****************************************************************
  // Field positions of the serial control register
  // ****************************************************************
  localparam int unsigned SPSF_B_RX_DONE = 0;
  localparam int unsigned SPSF_B_TX_DONE = 1;
  localparam int unsigned SPSF_B_NINTH = 2;
  localparam int unsigned SPSF_B_TX_NINTH = 3;
  localparam int unsigned SPSF_B_RX_EN = 4;
  localparam int unsigned SPSF_B_MP_EN = 5;
  localparam int unsigned SPSF_B_MODE_LO = 6;
  localparam int unsigned SPSF_B_MODE_HI = 7;

  // Field positions of the interrupt status and mask registers
  localparam int unsigned SPSF_I_RX = 0;
  localparam int unsigned SPSF_I_TX = 1;

  // ****************************************************************
  // Serial modes, coded as the two mode bits {high, low}
  // ****************************************************************
  typedef enum logic [1:0] {
    SPSF_MODE_SHIFT = 2'h0,
    SPSF_MODE_UART8 = 2'h1,
    SPSF_MODE_FIX9 = 2'h2,
    SPSF_MODE_VAR9 = 2'h3
  } spsf_mode_e;

endpackage

/* File: src/spsf_event_qual.sv */
// Purpose: Turns frame events of the shifter into flag set and load strobes.
// Assumes: Event inputs are one cycle pulses synchronous to clk.
// Notes:   Purely combinational; the caller registers the results.

`timescale 1ns/1ns
`default_nettype none

module spsf_event_qual
  import spsf_pkg::*;
(
  input wire spsf_pkg::spsf_mode_e mode,  // Current serial mode
  input wire logic mp_check_en,           // Multiprocessor check enable
  input wire logic tx_bit8_end,           // End of 8th bit time, transmit
  input wire logic tx_stop_begin,         // Stop bit starts being sent
  input wire logic rx_bit8_end,           // End of 8th bit time, receive
  input wire logic rx_stop_sample,        // Stop bit sampled
  input wire logic rx_ninth_bit,          // Received 9th data bit
  input wire logic rx_stop_bit,           // Received stop bit level
  output logic tx_done_set,               // Set transmit-done flag
  output logic rx_done_set,               // Set receive-done flag
  output logic ninth_load,                // Load received-ninth-bit flag
  output logic ninth_value                // Value to load
);

  // ****************************************************************
  // Mode decode
  // ****************************************************************
  wire logic is_shift;
  wire logic is_uart8;
  wire logic is_nine;
  wire logic accept_u8;
  wire logic accept_n9;

  assign is_shift = (mode == SPSF_MODE_SHIFT);
  assign is_uart8 = (mode == SPSF_MODE_UART8);
  assign is_nine = (mode == SPSF_MODE_FIX9) || (mode == SPSF_MODE_VAR9);

  // Multiprocessor check: a frame counts only if its qualifier bit is 1
  assign accept_u8 = !mp_check_en || rx_stop_bit;
  assign accept_n9 = !mp_check_en || rx_ninth_bit;

  // ****************************************************************
  // Transmit and receive completion
  // ****************************************************************
  assign tx_done_set = (is_shift && tx_bit8_end) ||
                       (!is_shift && tx_stop_begin);
  assign rx_done_set = (is_shift && rx_bit8_end) ||
                       (is_uart8 && rx_stop_sample && accept_u8) ||
                       (is_nine && rx_stop_sample && accept_n9);

  // ****************************************************************
  // Received ninth bit; never touched in shift mode
  // ****************************************************************
  assign ninth_load = !is_shift && rx_stop_sample &&
                      ((is_uart8 && accept_u8) ||
                       (is_nine && accept_n9));
  assign ninth_value = is_nine ? rx_ninth_bit : rx_stop_bit;

endmodule

`default_nettype wire

/* File: src/spsf_serial_flags.sv */
// Purpose: Serial control register with the received ninth bit and the
//          transmit and receive done flags, plus an interrupt front end.
// Assumes: Frame events come from a shifter on the same clock as pulses.
// Notes:   Software sees the register over a simple strobe port with read
//          data one cycle after the read strobe.
//
// Design decisions made here: strobed register access; the register offsets come from spsf_pkg.

`timescale 1ns/1ns
`default_nettype none

module spsf_serial_flags #(
  parameter int unsigned ADDR_W = spsf_pkg::SPSF_AW  // Register address width
) (
  input wire logic clk,                            // Core clock, 250 MHz
  input wire logic sys_rst,                        // Sync reset, active high
  input wire logic [ADDR_W-1:0] bus_addr,          // Register address
  input wire logic [spsf_pkg::SPSF_DW-1:0] bus_wdata, // Write data
  input wire logic bus_wr,                         // Write strobe
  input wire logic bus_rd,                         // Read strobe
  output logic [spsf_pkg::SPSF_DW-1:0] bus_rdata,  // Read data, next cycle
  input wire logic tx_bit8_end,                    // Tx 8th bit time ends
  input wire logic tx_stop_begin,                  // Tx stop bit begins
  input wire logic rx_bit8_end,                    // Rx 8th bit time ends
  input wire logic rx_stop_sample,                 // Rx stop bit sampled
  input wire logic rx_ninth_bit,                   // Rx 9th data bit
  input wire logic rx_stop_bit,                    // Rx stop bit level
  output spsf_pkg::spsf_mode_e serial_mode,        // Selected serial mode
  output logic multiprocessor_check_enable,        // Address check enable
  output logic rx_enable,                          // Receiver enable
  output logic tx_ninth_bit,                       // 9th bit to transmit
  output logic received_ninth_bit,                 // Received 9th bit flag
  output logic transmit_done_flag,                 // Transmit done flag
  output logic receive_done_flag,                  // Receive done flag
  output logic irq                                 // Level interrupt
);

  import spsf_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  logic [SPSF_DW-1:0] serial_control_q;
  logic [SPSF_DW-1:0] serial_control_d;
  logic [SPSF_IW-1:0] irq_stat_q;
  logic [SPSF_IW-1:0] irq_stat_d;
  logic [SPSF_IW-1:0] irq_mask_q;
  logic [SPSF_IW-1:0] irq_mask_d;
  logic [SPSF_DW-1:0] rdata_q;
  logic [SPSF_DW-1:0] rdata_d;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  wire logic hit_ctrl;
  wire logic hit_set;
  wire logic hit_clr;
  wire logic hit_stat;
  wire logic hit_mask;

  // Compare the port address with each register offset
  assign hit_ctrl = (bus_addr == ADDR_W'(SPSF_OFF_CTRL));
  assign hit_set = (bus_addr == ADDR_W'(SPSF_OFF_CTRL_SET));
  assign hit_clr = (bus_addr == ADDR_W'(SPSF_OFF_CTRL_CLR));
  assign hit_stat = (bus_addr == ADDR_W'(SPSF_OFF_IRQ_STAT));
  assign hit_mask = (bus_addr == ADDR_W'(SPSF_OFF_IRQ_MASK));

  wire logic wr_ctrl;
  wire logic wr_set;
  wire logic wr_clr;
  wire logic wr_mask;
  wire logic rd_stat;

  // Qualify the decode with the strobes
  assign wr_ctrl = bus_wr && hit_ctrl;
  assign wr_set = bus_wr && hit_set;
  assign wr_clr = bus_wr && hit_clr;
  assign wr_mask = bus_wr && hit_mask;
  assign rd_stat = bus_rd && hit_stat;

  // ****************************************************************
  // Frame event qualification
  // ****************************************************************
  wire spsf_mode_e cur_mode;
  wire logic tx_done_set;
  wire logic rx_done_set;
  wire logic ninth_load;
  wire logic ninth_value;

  // Mode bits are the top two bits of the control register
  assign cur_mode = spsf_mode_e'({serial_control_q[SPSF_B_MODE_HI],
                                  serial_control_q[SPSF_B_MODE_LO]});

  spsf_event_qual u_qual (
    .mode (cur_mode),
    .mp_check_en (serial_control_q[SPSF_B_MP_EN]),
    .tx_bit8_end (tx_bit8_end),
    .tx_stop_begin (tx_stop_begin),
    .rx_bit8_end (rx_bit8_end),
    .rx_stop_sample (rx_stop_sample),
    .rx_ninth_bit (rx_ninth_bit),
    .rx_stop_bit (rx_stop_bit),
    .tx_done_set (tx_done_set),
    .rx_done_set (rx_done_set),
    .ninth_load (ninth_load),
    .ninth_value (ninth_value)
  );

  // ****************************************************************
  // Software view of the next control value
  // ****************************************************************
  wire logic [SPSF_DW-1:0] sw_next;

  // Whole byte write, bit set, or bit clear; otherwise hold
  assign sw_next = wr_ctrl ? bus_wdata :
                   wr_set ? (serial_control_q | bus_wdata) :
                   wr_clr ? (serial_control_q & ~bus_wdata) :
                   serial_control_q;

  // ****************************************************************
  // Hardware set and clear vectors
  // ****************************************************************
  logic [SPSF_DW-1:0] hw_set;
  logic [SPSF_DW-1:0] hw_clr;

  // Hardware only ever sets the done flags; ninth bit loads either way
  always_comb begin
    hw_set = '0;
    hw_clr = '0;
    hw_set[SPSF_B_RX_DONE] = rx_done_set;
    hw_set[SPSF_B_TX_DONE] = tx_done_set;
    hw_set[SPSF_B_NINTH] = ninth_load && ninth_value;
    hw_clr[SPSF_B_NINTH] = ninth_load && !ninth_value;
  end

  // ****************************************************************
  // Per bit merge: a hardware event wins over a software write
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < SPSF_DW; gi++) begin : g_bit
      assign serial_control_d[gi] = hw_set[gi] ? 1'b1 :
                                    hw_clr[gi] ? 1'b0 :
                                    sw_next[gi];
    end
  endgenerate

  // ****************************************************************
  // Interrupt status, mask and read clear
  // ****************************************************************
  wire logic [SPSF_IW-1:0] irq_events;
  wire logic [SPSF_IW-1:0] stat_clr;

  // Events of the cycle survive a clearing read in the same cycle
  assign irq_events = {tx_done_set, rx_done_set};
  assign stat_clr = rd_stat ? SPSF_IRQ_ALL : SPSF_IRQ_RST;
  assign irq_stat_d = (irq_stat_q & ~stat_clr) | irq_events;
  assign irq_mask_d = wr_mask ? bus_wdata[SPSF_IW-1:0] : irq_mask_q;

  // ****************************************************************
  // Read data selection
  // ****************************************************************
  wire logic [SPSF_DW-1:0] rd_mux;

  // Set and clear offsets are write only; unmapped reads give zero
  assign rd_mux = hit_ctrl ? serial_control_q :
                  hit_stat ? {{(SPSF_DW-SPSF_IW){1'b0}}, irq_stat_q} :
                  hit_mask ? {{(SPSF_DW-SPSF_IW){1'b0}}, irq_mask_q} :
                  SPSF_RDATA_RST;
  assign rdata_d = bus_rd ? rd_mux : SPSF_RDATA_RST;

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Control register, all bits zero after reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      serial_control_q <= SPSF_CTRL_RST;
    end else begin
      serial_control_q <= serial_control_d;
    end
  end

  // Interrupt status and mask
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_stat_q <= SPSF_IRQ_RST;
      irq_mask_q <= SPSF_IRQ_RST;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
    end
  end

  // Read data, valid only in the cycle after the read strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_q <= SPSF_RDATA_RST;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Field views of the control register
  assign serial_mode = cur_mode;
  assign multiprocessor_check_enable = serial_control_q[SPSF_B_MP_EN];
  assign rx_enable = serial_control_q[SPSF_B_RX_EN];
  assign tx_ninth_bit = serial_control_q[SPSF_B_TX_NINTH];
  assign received_ninth_bit = serial_control_q[SPSF_B_NINTH];
  assign transmit_done_flag = serial_control_q[SPSF_B_TX_DONE];
  assign receive_done_flag = serial_control_q[SPSF_B_RX_DONE];

  // Bus read data and interrupt level
  assign bus_rdata = rdata_q;
  assign irq = |(irq_stat_q & irq_mask_q);

endmodule

`default_nettype wire

/* File: sim/spsf_flags_checker.sv */
// Purpose: Concurrent checks on the ports of the serial status flags.
// Assumes: Frame events are one cycle pulses on clk.
// Notes:   Ninth bit checks skip cycles that carry a bus write.
`timescale 1ns/1ns
`default_nettype none
module spsf_flags_checker
  import spsf_pkg::*;
#(
  parameter int unsigned ADDR_W = SPSF_AW  // Register address width
) (
  input wire logic clk,                           // Core clock
  input wire logic sys_rst,                       // Sync reset
  input wire logic [ADDR_W-1:0] bus_addr,         // Register address
  input wire logic [SPSF_DW-1:0] bus_wdata,       // Write data
  input wire logic bus_wr,                        // Write strobe
  input wire logic bus_rd,                        // Read strobe
  input wire logic [SPSF_DW-1:0] bus_rdata,       // Read data
  input wire logic tx_bit8_end,                   // Tx 8th bit ends
  input wire logic tx_stop_begin,                 // Tx stop begins
  input wire logic rx_bit8_end,                   // Rx 8th bit ends
  input wire logic rx_stop_sample,                // Rx stop sampled
  input wire logic rx_ninth_bit,                  // Rx 9th bit
  input wire logic rx_stop_bit,                   // Rx stop bit
  input wire spsf_pkg::spsf_mode_e serial_mode,   // Serial mode
  input wire logic multiprocessor_check_enable,   // Check enable
  input wire logic rx_enable,                     // Receiver enable
  input wire logic tx_ninth_bit,                  // 9th bit to send
  input wire logic received_ninth_bit,            // Received 9th bit
  input wire logic transmit_done_flag,            // Tx done flag
  input wire logic receive_done_flag,             // Rx done flag
  input wire logic irq                            // Interrupt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Register image and frame acceptance
  wire logic [7:0] ctrl_w = {serial_mode, multiprocessor_check_enable,
    rx_enable, tx_ninth_bit, received_ninth_bit, transmit_done_flag,
    receive_done_flag};
  wire logic m0 = serial_mode == SPSF_MODE_SHIFT;
  wire logic m1 = serial_mode == SPSF_MODE_UART8;
  wire logic mpc = multiprocessor_check_enable;
  wire logic rx_ok = m1 ? (!mpc || rx_stop_bit) : (!mpc || rx_ninth_bit);
  sequence s_ctrl_read;
    bus_rd && bus_addr == SPSF_OFF_CTRL;
  endsequence
  sequence s_frame_m23;
    rx_stop_sample && !m0 && !m1 && rx_ok && !bus_wr;
  endsequence

  AST_NINTH_M23: assert property (s_frame_m23 |=>
    received_ninth_bit == $past(rx_ninth_bit)) else $error("ninth bit");
  AST_STOP_M1: assert property (rx_stop_sample && m1 && !mpc && !bus_wr
    |=> received_ninth_bit == $past(rx_stop_bit)) else $error("stop bit");
  AST_NINTH_M0: assert property (m0 && !bus_wr
    |=> $stable(received_ninth_bit)) else $error("ninth bit in mode 0");
  AST_TX_M0: assert property (tx_bit8_end && m0
    |=> transmit_done_flag) else $error("tx done mode 0");
  AST_TX_M13: assert property (tx_stop_begin && !m0
    |=> transmit_done_flag) else $error("tx done modes 1-3");
  AST_RX_M0: assert property (rx_bit8_end && m0
    |=> receive_done_flag) else $error("rx done mode 0");
  AST_NO_HW_CLR: assert property (($fell(transmit_done_flag)
    || $fell(receive_done_flag)) && !$past(sys_rst) |-> $past(bus_wr))
    else $error("flag cleared without write");
  AST_RESET: assert property ($fell(sys_rst)
    |-> ctrl_w == 8'h00 && !irq) else $error("reset value");
  AST_CTRL_READ: assert property (s_ctrl_read |=>
    bus_rdata == $past(ctrl_w)) else $error("ctrl read data");
  AST_RX_M13: assert property (rx_stop_sample && !m0 && rx_ok
    |=> receive_done_flag) else $error("rx done modes 1-3");
endmodule
bind spsf_serial_flags spsf_flags_checker #(.ADDR_W(ADDR_W)) u_chk (
  .clk(clk), .sys_rst(sys_rst), .bus_addr(bus_addr),
  .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
  .bus_rdata(bus_rdata), .tx_bit8_end(tx_bit8_end),
  .tx_stop_begin(tx_stop_begin), .rx_bit8_end(rx_bit8_end),
  .rx_stop_sample(rx_stop_sample), .rx_ninth_bit(rx_ninth_bit),
  .rx_stop_bit(rx_stop_bit), .serial_mode(serial_mode),
  .multiprocessor_check_enable(multiprocessor_check_enable),
  .rx_enable(rx_enable), .tx_ninth_bit(tx_ninth_bit),
  .received_ninth_bit(received_ninth_bit),
  .transmit_done_flag(transmit_done_flag),
  .receive_done_flag(receive_done_flag), .irq(irq));
`default_nettype wire

/* File: sim/spsf_line_model.sv */
// Purpose: Far side serial line seen as frame events from the shifter.
// Assumes: One event per call, one cycle long.
// Notes:   Bit levels are inverted after the event cycle until the next call.
`timescale 1ns/1ns
`default_nettype none
module spsf_line_model (
  input wire logic clk,              // Core clock
  output logic tx_bit8_end = 1'b0,   // Tx 8th bit ends
  output logic tx_stop_begin = 1'b0, // Tx stop begins
  output logic rx_bit8_end = 1'b0,   // Rx 8th bit ends
  output logic rx_stop_sample = 1'b0,// Rx stop sampled
  output logic rx_ninth_bit = 1'b0,  // Rx 9th bit
  output logic rx_stop_bit = 1'b0    // Rx stop bit
);
  // Kind 0 tx 8th bit, 1 tx stop, 2 rx 8th bit, 3 rx stop sampled
  task automatic frame(input int kind, input logic ninth, input logic stop);
    @(posedge clk);
    tx_bit8_end <= kind == 0;
    tx_stop_begin <= kind == 1;
    rx_bit8_end <= kind == 2;
    rx_stop_sample <= kind == 3;
    rx_ninth_bit <= ninth;
    rx_stop_bit <= stop;
    @(posedge clk);
    {tx_bit8_end, tx_stop_begin, rx_bit8_end, rx_stop_sample} <= 4'h0;
    rx_ninth_bit <= !ninth;
    rx_stop_bit <= !stop;
  endtask
endmodule
`default_nettype wire

/* File: sim/test_spsf_serial_flags.sv */
// Purpose: Self-checking bench for the serial status flags.
// Assumes: Reads return data one cycle after the strobe.
// Notes:   Expected values come from the mode and frame stimulus.
`timescale 1ns/1ns
`default_nettype none
module test_spsf_serial_flags;
  import spsf_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] bus_addr = 4'h0;
  logic [7:0] bus_wdata = 8'h00;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [7:0] bus_rdata, base;
  logic tx8, txs, rx8, rxs, rx9, rxst, irq;
  int err_total = 0;
  int checks_done = 0;
  always #2 clk = ~clk;
  spsf_serial_flags dut (.clk(clk), .sys_rst(sys_rst), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .tx_bit8_end(tx8), .tx_stop_begin(txs),
    .rx_bit8_end(rx8), .rx_stop_sample(rxs), .rx_ninth_bit(rx9),
    .rx_stop_bit(rxst), .serial_mode(), .multiprocessor_check_enable(),
    .rx_enable(), .tx_ninth_bit(), .received_ninth_bit(),
    .transmit_done_flag(), .receive_done_flag(), .irq(irq));
  spsf_line_model u_line (.clk(clk), .tx_bit8_end(tx8), .tx_stop_begin(txs),
    .rx_bit8_end(rx8), .rx_stop_sample(rxs), .rx_ninth_bit(rx9),
    .rx_stop_bit(rxst));
  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Register bus write and read
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1 chk(bus_rdata, exp);
  endtask
  task automatic end_of_test;
    $display("Checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Run limit
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    end_of_test;
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    rd(SPSF_OFF_CTRL, 8'h00);
    rd(SPSF_OFF_IRQ_MASK, 8'h00);
    rd(4'hF, 8'h00);
    wr(SPSF_OFF_IRQ_MASK, 8'h03);
    u_line.frame(1, 1'b0, 1'b0);
    u_line.frame(3, 1'b1, 1'b1);
    rd(SPSF_OFF_CTRL, 8'h00);
    u_line.frame(0, 1'b0, 1'b0);
    #1 chk({7'h00, irq}, 8'h01);
    u_line.frame(2, 1'b1, 1'b1);
    rd(SPSF_OFF_CTRL, 8'h03);
    rd(SPSF_OFF_IRQ_STAT, 8'h03);
    rd(SPSF_OFF_IRQ_STAT, 8'h00);
    chk({7'h00, irq}, 8'h00);
    rd(SPSF_OFF_CTRL, 8'h03);
    wr(SPSF_OFF_CTRL_CLR, 8'h03);
    rd(SPSF_OFF_CTRL, 8'h00);
    for (int m = 1; m < 4; m++) begin
      base = {m[1:0], 6'h00};
      wr(SPSF_OFF_CTRL, base);
      u_line.frame(0, 1'b0, 1'b0);
      u_line.frame(2, 1'b0, 1'b0);
      rd(SPSF_OFF_CTRL, base);
      u_line.frame(1, 1'b0, 1'b0);
      u_line.frame(3, 1'b1, 1'b0);
      rd(SPSF_OFF_CTRL, base | (m == 1 ? 8'h03 : 8'h07));
      u_line.frame(3, 1'b0, 1'b1);
      rd(SPSF_OFF_CTRL, base | (m == 1 ? 8'h07 : 8'h03));
      wr(SPSF_OFF_CTRL_CLR, 8'h07);
      rd(SPSF_OFF_CTRL, base);
    end
    wr(SPSF_OFF_CTRL, 8'hE0);
    wr(SPSF_OFF_IRQ_MASK, 8'h02);
    // Sticky events of the mode loop are cleared before the mask test
    rd(SPSF_OFF_IRQ_STAT, 8'h03);
    u_line.frame(3, 1'b0, 1'b1);
    rd(SPSF_OFF_CTRL, 8'hE0);
    u_line.frame(3, 1'b1, 1'b0);
    #1 chk({7'h00, irq}, 8'h00);
    rd(SPSF_OFF_CTRL, 8'hE5);
    wr(SPSF_OFF_CTRL, 8'h60);
    u_line.frame(3, 1'b1, 1'b0);
    rd(SPSF_OFF_CTRL, 8'h60);
    wr(SPSF_OFF_CTRL_SET, 8'h18);
    rd(SPSF_OFF_CTRL, 8'h78);
    wr(SPSF_OFF_IRQ_STAT, 8'h03);
    rd(SPSF_OFF_IRQ_STAT, 8'h01);
    wr(SPSF_OFF_CTRL, 8'hFF);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd(SPSF_OFF_CTRL, 8'h00);
    end_of_test;
  end
endmodule
`default_nettype wire
